// ---- shared/spd_params.svh ----
// Register indices, field positions, reset values and widths of the port-state block
`ifndef SPD_PARAMS_SVH
`define SPD_PARAMS_SVH

// Register indices; byte address is four times the index
`define SPD_IDX_GCTL2 8'h02
`define SPD_IDX_P1CTL 8'h12
`define SPD_IDX_P2CTL 8'h22
`define SPD_IDX_DSCP_FIRST 8'h60
`define SPD_IDX_DSCP_LAST 8'h6f
`define SPD_IDX_STATUS 8'hc8

// Address decode
`define SPD_IDX_LSB 2
`define SPD_IDX_MSB 9
`define SPD_ADDR_TOP_MSB 31

// Port control field positions inside the 3-bit port control word
`define SPD_PCTL_TXEN 2
`define SPD_PCTL_RXEN 1
`define SPD_PCTL_LDIS 0
// Same fields in the 8-bit port control register
`define SPD_REG_TXEN 2
`define SPD_REG_RXEN 1
`define SPD_REG_LDIS 0

// Flush bits in global control 2
`define SPD_GCTL2_FLUSH_DYN 5
`define SPD_GCTL2_FLUSH_STA 4

// Port control settings
`define SPD_PCTL_RESET 3'h6
`define SPD_PCTL_DISCARD 3'h1
`define SPD_PCTL_LEARNING 3'h0
`define SPD_PCTL_FORWARDING 3'h6

// Egress masks: bit 0 port 1, bit 1 port 2, bit 2 processor port
`define SPD_MASK_NONE 3'h0
`define SPD_MASK_CPU 3'h4

// Code point table
`define SPD_DSCP_REGS 16
`define SPD_DSCP_RESET 8'h00
`define SPD_TOS_DSCP_MSB 7
`define SPD_TOS_DSCP_LSB 2

`endif

// ---- shared/spd_pkg.sv ----
// Types shared by the port-state and code-point priority block
package spd_pkg;
  typedef enum logic [1:0] {
    SPD_DISCARDING,
    SPD_LEARNING,
    SPD_FORWARDING,
    SPD_NONSTANDARD
  } spd_stp_t;

  typedef logic [2:0] spd_pctl_t;
  typedef logic [2:0] spd_mask_t;
endpackage : spd_pkg

// ---- core/spd_core.sv ----
// Port spanning tree state control and code point priority decode, AHB-Lite slave
//
// Functional notes
// - Top six bits of the type-of-service byte select a bit of a 64-bit priority table.
// - The 64-bit table sits in eight 8-bit registers numbered 96 through 103.
// - Port 3 is the processor port; only ports 1 and 2 have state control.
// - Ports 1 and 2 take one of four states from transmit, receive, learning bits.
// - Enables 0 and learning disable 1: no user traffic in or out, no learning.
// - Override-matched static entries still reach the processor with the port disabled.
// - With learning disable set the port learns no source addresses.
// - Enables 0, learning disable 0: learn, but pass traffic only to the processor.
// - Both enables 1, learning disable 0: normal forwarding and learning.
// - Directed frames from the processor are sent even while transmit enable is 0.
// - Learning disabled and both flush bits set: flush that port's table entries.
// - Rapid discarding uses the disabled setting: enables 0, learning disable 1.
`include "spd_params.svh"
`timescale 1ns/1ns
`default_nettype none

module spd_core (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Code point priority
  input wire logic tos_valid_in,
  input wire logic [7:0] tos_in,
  output logic prio_valid_out,
  output logic prio_out,
  // Received frame from port 1 or 2 after address lookup
  input wire logic fr_valid_in,
  input wire logic fr_port_in,
  input wire spd_pkg::spd_mask_t fr_dest_in,
  input wire logic fr_override_in,
  output logic fwd_valid_out,
  output spd_pkg::spd_mask_t fwd_mask_out,
  output logic learn_out,
  // Frame directed by the processor
  input wire logic dir_valid_in,
  input wire logic [1:0] dir_tag_in,
  output logic dir_valid_out,
  output logic dir_lookup_out,
  output logic [1:0] dir_mask_out,
  // Table flush request per network port
  output logic [1:0] flush_out
);
  import spd_pkg::*;

  logic rst_meta_r;
  logic rst_n;
  logic [7:0] dscp_r [`SPD_DSCP_REGS];
  spd_pctl_t pctl_r [2];
  logic [1:0] gflush_r;
  logic flush_pend_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] idx_r;
  logic addr_ok_r;

  // Reset release through two flops
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  function automatic spd_stp_t stp_state(input spd_pctl_t c);
    if (c == `SPD_PCTL_DISCARD) begin
      return SPD_DISCARDING;
    end else if (c == `SPD_PCTL_LEARNING) begin
      return SPD_LEARNING;
    end else if (c == `SPD_PCTL_FORWARDING) begin
      return SPD_FORWARDING;
    end
    return SPD_NONSTANDARD;
  endfunction : stp_state

  // Bus decode
  wire addr_phase_w = hsel_in && htrans_in[1] && hready_in;
  wire [7:0] a_idx_w = haddr_in[`SPD_IDX_MSB:`SPD_IDX_LSB];
  wire a_top_ok_w = (haddr_in[`SPD_ADDR_TOP_MSB:`SPD_IDX_MSB + 1] == '0);
  wire wr_now_w = wr_pend_r && addr_ok_r;
  wire is_dscp_w = (idx_r >= `SPD_IDX_DSCP_FIRST) && (idx_r <= `SPD_IDX_DSCP_LAST);
  wire [3:0] dscp_sel_w = 4'(idx_r - `SPD_IDX_DSCP_FIRST);
  wire wr_dscp_w = wr_now_w && is_dscp_w;
  wire wr_p1_w = wr_now_w && (idx_r == `SPD_IDX_P1CTL);
  wire wr_p2_w = wr_now_w && (idx_r == `SPD_IDX_P2CTL);
  wire wr_g2_w = wr_now_w && (idx_r == `SPD_IDX_GCTL2);
  wire [7:0] wdat_w = hwdata_in[7:0];
  wire flush_req_w = wr_g2_w && wdat_w[`SPD_GCTL2_FLUSH_DYN] && wdat_w[`SPD_GCTL2_FLUSH_STA];
  wire spd_pctl_t wr_pctl_w = {wdat_w[`SPD_REG_TXEN], wdat_w[`SPD_REG_RXEN],
                               wdat_w[`SPD_REG_LDIS]};
  // Ports with learning disabled are the ones a flush may empty
  wire [1:0] ld_w = {pctl_r[1][`SPD_PCTL_LDIS], pctl_r[0][`SPD_PCTL_LDIS]};

  function automatic logic [7:0] pctl_reg(input spd_pctl_t c);
    logic [7:0] v;
    v = 8'h00;
    v[`SPD_REG_TXEN] = c[`SPD_PCTL_TXEN];
    v[`SPD_REG_RXEN] = c[`SPD_PCTL_RXEN];
    v[`SPD_REG_LDIS] = c[`SPD_PCTL_LDIS];
    return v;
  endfunction : pctl_reg

  spd_stp_t st1_w;
  spd_stp_t st2_w;
  assign st1_w = stp_state(pctl_r[0]);
  assign st2_w = stp_state(pctl_r[1]);
  wire [7:0] g2_reg_w = {2'b00, gflush_r, 4'h0};
  wire [7:0] stat_reg_w = {3'b000, prio_out, 2'(st2_w), 2'(st1_w)};
  wire [7:0] rd_byte_w =
    !addr_ok_r ? 8'h00 :
    is_dscp_w ? dscp_r[dscp_sel_w] :
    (idx_r == `SPD_IDX_P1CTL) ? pctl_reg(pctl_r[0]) :
    (idx_r == `SPD_IDX_P2CTL) ? pctl_reg(pctl_r[1]) :
    (idx_r == `SPD_IDX_GCTL2) ? g2_reg_w :
    (idx_r == `SPD_IDX_STATUS) ? stat_reg_w : 8'h00;

  // Reads take one wait state so the word comes from a flop after any earlier write
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r <= 8'h00;
      addr_ok_r <= 1'b0;
      hreadyout_out <= 1'b1;
      hrdata_out <= 32'h0000_0000;
      hresp_out <= 1'b0;
    end else if (ce_in) begin
      wr_pend_r <= addr_phase_w && hwrite_in;
      rd_pend_r <= addr_phase_w && !hwrite_in;
      hreadyout_out <= !(addr_phase_w && !hwrite_in);
      if (addr_phase_w) begin
        idx_r <= a_idx_w;
        addr_ok_r <= a_top_ok_w;
      end
      if (rd_pend_r) begin
        hrdata_out <= {24'h00_0000, rd_byte_w};
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SPD_DSCP_REGS; i++) begin
        dscp_r[i] <= `SPD_DSCP_RESET;
      end
    end else if (ce_in && wr_dscp_w) begin
      dscp_r[dscp_sel_w] <= wdat_w;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pctl_r[0] <= `SPD_PCTL_RESET;
      pctl_r[1] <= `SPD_PCTL_RESET;
    end else if (ce_in) begin
      if (wr_p1_w) begin
        pctl_r[0] <= wr_pctl_w;
      end
      if (wr_p2_w) begin
        pctl_r[1] <= wr_pctl_w;
      end
    end
  end

  // Flush bits clear themselves once the request has gone out
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gflush_r <= 2'b00;
      flush_pend_r <= 1'b0;
      flush_out <= 2'b00;
    end else if (ce_in) begin
      flush_pend_r <= flush_req_w;
      flush_out <= flush_pend_r ? ld_w : 2'b00;
      if (flush_req_w) begin
        gflush_r <= 2'b11;
      end else if (wr_g2_w) begin
        gflush_r <= {wdat_w[`SPD_GCTL2_FLUSH_DYN], wdat_w[`SPD_GCTL2_FLUSH_STA]};
      end else if (flush_pend_r) begin
        gflush_r <= 2'b00;
      end
    end
  end

  // Full decode of the six code point bits
  // Registers 104 to 111 are stored and read back but lie past the 64 code points
  wire [63:0] dscp_flat_w = {dscp_r[7], dscp_r[6], dscp_r[5], dscp_r[4],
                             dscp_r[3], dscp_r[2], dscp_r[1], dscp_r[0]};
  wire [5:0] dscp_w = tos_in[`SPD_TOS_DSCP_MSB:`SPD_TOS_DSCP_LSB];
  wire prio_bit_w = dscp_flat_w[dscp_w];

  // Forwarding decision for a received frame
  wire spd_pctl_t ing_w = fr_port_in ? pctl_r[1] : pctl_r[0];
  wire spd_mask_t self_w = fr_port_in ? 3'h2 : 3'h1;
  // Processor port has no state control and is always a legal egress
  wire spd_mask_t eg_ok_w = {1'b1, pctl_r[1][`SPD_PCTL_TXEN], pctl_r[0][`SPD_PCTL_TXEN]} & ~self_w;
  // Closed port drops user traffic; learning port reaches only the processor
  wire spd_mask_t base_w = ing_w[`SPD_PCTL_RXEN] ? (fr_dest_in & eg_ok_w) :
                           ing_w[`SPD_PCTL_LDIS] ? `SPD_MASK_NONE : (fr_dest_in & `SPD_MASK_CPU);
  // Override hits always reach the processor
  wire spd_mask_t fwd_w = base_w | (fr_override_in ? `SPD_MASK_CPU : `SPD_MASK_NONE);

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prio_valid_out <= 1'b0;
      prio_out <= 1'b0;
      fwd_valid_out <= 1'b0;
      fwd_mask_out <= `SPD_MASK_NONE;
      learn_out <= 1'b0;
      dir_valid_out <= 1'b0;
      dir_lookup_out <= 1'b0;
      dir_mask_out <= 2'b00;
    end else if (ce_in) begin
      prio_valid_out <= tos_valid_in;
      if (tos_valid_in) begin
        prio_out <= prio_bit_w;
      end
      fwd_valid_out <= fr_valid_in;
      fwd_mask_out <= fr_valid_in ? fwd_w : `SPD_MASK_NONE;
      // Learning follows the inverse of learning disable
      learn_out <= fr_valid_in && !ing_w[`SPD_PCTL_LDIS];
      dir_valid_out <= dir_valid_in;
      dir_lookup_out <= dir_valid_in && (dir_tag_in == 2'b00);
      dir_mask_out <= dir_valid_in ? dir_tag_in : 2'b00;
    end
  end

  default clocking dflt_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n);

  prio_decode_a: assert property (
    ce_in && tos_valid_in |=> prio_valid_out && (prio_out == $past(prio_bit_w)))
    else $error("priority does not match table bit");

  dscp_store_a: assert property (
    ce_in && wr_dscp_w |=> dscp_r[$past(dscp_sel_w)] == $past(wdat_w))
    else $error("code point register write lost");

  cpu_port_a: assert property (
    ce_in && fr_valid_in && ing_w[`SPD_PCTL_RXEN] && fr_dest_in[2] |=> fwd_mask_out[2])
    else $error("processor port refused a frame");

  port_indep_a: assert property (
    ce_in && wr_p1_w |=> $stable(pctl_r[1]))
    else $error("port 1 write touched port 2");

  state_set_a: assert property (
    ce_in && wr_p2_w && (wr_pctl_w == `SPD_PCTL_LEARNING) |=> st2_w == SPD_LEARNING)
    else $error("port state not taken from control bits");

  closed_drop_a: assert property (
    ce_in && fr_valid_in && (ing_w == `SPD_PCTL_DISCARD) && !fr_override_in
    |=> fwd_valid_out && (fwd_mask_out == `SPD_MASK_NONE) && !learn_out)
    else $error("closed port passed traffic");

  override_cpu_a: assert property (
    ce_in && fr_valid_in && fr_override_in |=> fwd_mask_out[2])
    else $error("override frame not sent to processor");

  no_learn_a: assert property (
    ce_in && fr_valid_in && ing_w[`SPD_PCTL_LDIS] |=> !learn_out)
    else $error("learned while learning disabled");

  learn_cpu_a: assert property (
    ce_in && fr_valid_in && (ing_w == `SPD_PCTL_LEARNING)
    |=> learn_out && (fwd_mask_out[1:0] == 2'b00))
    else $error("learning port forwarded user traffic");

  fwd_normal_a: assert property (
    ce_in && fr_valid_in && (pctl_r[0] == `SPD_PCTL_FORWARDING)
    && (pctl_r[1] == `SPD_PCTL_FORWARDING) && !fr_override_in
    |=> learn_out && (fwd_mask_out == ($past(fr_dest_in) & ~$past(self_w))))
    else $error("forwarding port mishandled frame");

  directed_tx_a: assert property (
    ce_in && dir_valid_in |=> dir_valid_out && (dir_mask_out == $past(dir_tag_in)))
    else $error("directed frame not sent");

  flush_seq_a: assert property (
    ce_in && flush_req_w ##1 ce_in |=> flush_out == $past(ld_w))
    else $error("flush not issued for learning-disabled ports");

  rd_wait_a: assert property (
    ce_in && addr_phase_w && !hwrite_in |=> !hreadyout_out ##1 (hreadyout_out || !ce_in))
    else $error("read wait state wrong");

  discard_state_a: assert property (
    ce_in && wr_p1_w && (wr_pctl_w == `SPD_PCTL_DISCARD) |=> st1_w == SPD_DISCARDING)
    else $error("discarding setting not decoded");

  dir_lookup_a: assert property (
    ce_in && dir_valid_in && (dir_tag_in == 2'b00) |=> dir_valid_out && dir_lookup_out)
    else $error("directed lookup frame not flagged");

  flush_pulse_a: assert property (
    ce_in && (flush_out != 2'b00) && !flush_pend_r |=> flush_out == 2'b00)
    else $error("flush request longer than one cycle");

  fwd_idle_a: assert property (
    !fwd_valid_out |-> (fwd_mask_out == `SPD_MASK_NONE) && !learn_out)
    else $error("egress mask without a frame");

  prio_hold_a: assert property (
    ce_in && !tos_valid_in |=> $stable(prio_out))
    else $error("priority changed without a request");

  ce_freeze_a: assert property (
    !ce_in |=> $stable(pctl_r[0]) && $stable(pctl_r[1]) && $stable(prio_valid_out)
    && $stable(fwd_valid_out) && $stable(hreadyout_out))
    else $error("state moved with clock enable low");

  override_cov: cover property (fr_valid_in && ce_in && fr_override_in && (ing_w == `SPD_PCTL_DISCARD));
  learn_cov: cover property (fr_valid_in && ce_in && (ing_w == `SPD_PCTL_LEARNING));
  flush_cov: cover property (flush_out != 2'b00);
  prio_cov: cover property (prio_valid_out && prio_out);
  dir_cov: cover property (dir_valid_out && !dir_lookup_out);

endmodule : spd_core

`default_nettype wire

// ---- testbench/spd_host_model.sv ----
// Processor model on the processor port: directs frames, drops processor copies while a port is not open
`timescale 1ns/1ns
`default_nettype none
module spd_host_model (
  input wire logic clk_in,
  input wire logic [1:0] open_in,
  input wire logic fwd_valid_in,
  input wire spd_pkg::spd_mask_t fwd_mask_in,
  output logic dir_valid_out,
  output logic [1:0] dir_tag_out,
  output int dropped_out
);
  import spd_pkg::*;
  initial begin
    dir_valid_out = 1'b0;
    dir_tag_out = 2'h3;
    dropped_out = 0;
  end
  function automatic logic rapid_unit(input logic [7:0] ver);
    return ver == 8'h02;
  endfunction : rapid_unit
  always @(posedge clk_in) begin
    if (fwd_valid_in === 1'b1 && fwd_mask_in[2] === 1'b1 && open_in !== 2'h3) begin
      dropped_out <= dropped_out + 1;
    end
  end
  task automatic direct(input logic [1:0] tag, output logic sent);
    sent = (!tag[0] || open_in[0]) && (!tag[1] || open_in[1]);
    if (sent) begin
      dir_valid_out <= 1'b1;
      dir_tag_out <= tag;
      @(posedge clk_in);
      dir_valid_out <= 1'b0;
      dir_tag_out <= ~tag;
    end
  endtask : direct
endmodule : spd_host_model
`default_nettype wire

// ---- testbench/spd_core_tb_top.sv ----
// Self-checking bench for the port-state and code point block
`include "spd_params.svh"
`timescale 1ns/1ns
`default_nettype none
module spd_core_tb_top;
  import spd_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, tos_valid = 1'b0;
  logic fr_valid = 1'b0, fr_port = 1'b0, fr_ovr = 1'b0, ce = 1'b1, sent;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
  logic [1:0] htrans = 2'h0, open = 2'h3, dir_tag, dir_mask, flush, fl;
  logic [7:0] tos = 8'h00;
  logic hready, hresp, prio_valid, prio, fwd_valid, learn, dir_valid, dir_valid_o, dir_lookup;
  spd_mask_t fr_dest = 3'h0, fwd_mask;
  int dropped, miscompares = 0, compares = 0, pulses;
  logic [7:0] tv [5] = '{8'h00, 8'h04, 8'h24, 8'hfc, 8'hf8};
  logic ev [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  initial forever #5 clk = ~clk;
  spd_core spd_core_inst (.sys_clk_in(clk), .arst_n_in(arst_n), .ce_in(ce), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .tos_valid_in(tos_valid), .tos_in(tos), .prio_valid_out(prio_valid),
    .prio_out(prio), .fr_valid_in(fr_valid), .fr_port_in(fr_port), .fr_dest_in(fr_dest),
    .fr_override_in(fr_ovr), .fwd_valid_out(fwd_valid), .fwd_mask_out(fwd_mask),
    .learn_out(learn), .dir_valid_in(dir_valid), .dir_tag_in(dir_tag),
    .dir_valid_out(dir_valid_o), .dir_lookup_out(dir_lookup), .dir_mask_out(dir_mask),
    .flush_out(flush));
  spd_host_model spd_host_model_inst (.clk_in(clk), .open_in(open), .fwd_valid_in(fwd_valid),
    .fwd_mask_in(fwd_mask), .dir_valid_out(dir_valid), .dir_tag_out(dir_tag),
    .dropped_out(dropped));
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        miscompares++;
        summarize();
      end
      @(posedge clk);
    end
  endtask : wait_rdy
  // Released address and data lines show the inverse so stale values never match
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~{22'h0, idx, 2'h0};
    hwdata <= wr ? d : ~d;
    wait_rdy();
    q = hrdata;
    hwdata <= ~d;
  endtask : bus
  task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    chk(nm, q, exp);
  endtask : rd
  task automatic frame(input logic p, input spd_mask_t dst, input logic ov,
                       input spd_mask_t em, input logic el);
    fr_valid <= 1'b1;
    fr_port <= p;
    fr_dest <= dst;
    fr_ovr <= ov;
    @(posedge clk);
    fr_valid <= 1'b0;
    fr_dest <= ~dst;
    #1;
    chk("fwd_valid", fwd_valid, 1);
    chk("fwd_mask", fwd_mask, em);
    chk("learn", learn, el);
    @(posedge clk);
  endtask : frame
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd("p1ctl", `SPD_IDX_P1CTL, `SPD_PCTL_RESET);
    rd("p2ctl", `SPD_IDX_P2CTL, `SPD_PCTL_RESET);
    rd("dscp0", `SPD_IDX_DSCP_FIRST, `SPD_DSCP_RESET);
    bus(1'b1, 8'h05, 32'h0000_00ff);
    rd("unmapped", 8'h05, 32'h0000_0000);
    bus(1'b1, `SPD_IDX_DSCP_FIRST, 32'h0000_0001);
    bus(1'b1, 8'h61, 32'h0000_0002);
    // Code points 56 to 63 live in register 103
    bus(1'b1, 8'h67, 32'h0000_0080);
    bus(1'b1, `SPD_IDX_DSCP_LAST, 32'h0000_0080);
    rd("dscp15", `SPD_IDX_DSCP_LAST, 32'h0000_0080);
    chk("hresp", hresp, 0);
    for (int i = 0; i < 5; i++) begin
      tos_valid <= 1'b1;
      tos <= tv[i];
      @(posedge clk);
      tos_valid <= 1'b0;
      tos <= ~tv[i];
      #1;
      chk("prio_valid", prio_valid, 1);
      chk("prio", prio, ev[i]);
      @(posedge clk);
    end
    // A request while the clock enable is low must be ignored
    ce <= 1'b0;
    tos_valid <= 1'b1;
    tos <= 8'h00;
    @(posedge clk);
    #1;
    chk("prio_frozen", prio_valid, 0);
    @(posedge clk);
    ce <= 1'b1;
    tos_valid <= 1'b0;
    bus(1'b1, `SPD_IDX_P1CTL, `SPD_PCTL_DISCARD);
    open <= 2'h2;
    frame(1'b0, 3'h6, 1'b0, `SPD_MASK_NONE, 1'b0);
    frame(1'b0, 3'h2, 1'b1, `SPD_MASK_CPU, 1'b0);
    #1;
    chk("dropped", dropped, 1);
    @(posedge clk);
    frame(1'b1, 3'h5, 1'b0, `SPD_MASK_CPU, 1'b1);
    rd("p2ctl", `SPD_IDX_P2CTL, `SPD_PCTL_FORWARDING);
    bus(1'b1, `SPD_IDX_P1CTL, `SPD_PCTL_LEARNING);
    open <= 2'h3;
    frame(1'b0, 3'h6, 1'b0, `SPD_MASK_CPU, 1'b1);
    for (int t = 0; t < 4; t++) begin
      spd_host_model_inst.direct(t[1:0], sent);
      #1;
      chk("dir_valid", dir_valid_o, 1);
      chk("dir_mask", dir_mask, t[1:0]);
      chk("dir_lookup", dir_lookup, t == 0);
      @(posedge clk);
    end
    bus(1'b1, `SPD_IDX_P1CTL, `SPD_PCTL_FORWARDING);
    frame(1'b0, 3'h7, 1'b0, 3'h6, 1'b1);
    bus(1'b1, `SPD_IDX_P1CTL, `SPD_PCTL_DISCARD);
    bus(1'b1, `SPD_IDX_GCTL2, 32'h0000_0030);
    fl = 2'h0;
    pulses = 0;
    for (int i = 0; i < 6; i++) begin
      #1;
      if (flush !== 2'h0) begin
        fl = flush;
        pulses++;
      end
      @(posedge clk);
    end
    chk("flush", fl, 2'h1);
    chk("flush_pulses", pulses, 1);
    rd("gctl2", `SPD_IDX_GCTL2, 32'h0000_0000);
    rd("status", `SPD_IDX_STATUS, 32'h0000_0008);
    bus(1'b1, `SPD_IDX_P2CTL, `SPD_PCTL_LEARNING);
    rd("status_p2", `SPD_IDX_STATUS, 32'h0000_0004);
    summarize();
  end
endmodule : spd_core_tb_top
`default_nettype wire
